// ---- logic/osd_pkg.sv ----
// constants and types for the output and supply diagnostic status block
package osd_pkg;

    // outputs seven to eleven
    localparam int OSD_NUM_OUT = 5;

    // register selection on the register port
    localparam logic OSD_SEL_STATUS = 1'h0;
    localparam logic OSD_SEL_CONFIG = 1'h1;

    // status word layout: output k of the group has its over-current flag at
    // OSD_OC_TOP_BIT - 2k and its under-current flag at OSD_UC_TOP_BIT - 2k
    localparam int OSD_OC_TOP_BIT = 15;
    localparam int OSD_UC_TOP_BIT = 14;
    localparam int OSD_UV_BIT = 3;
    localparam int OSD_OV_BIT = 2;
    localparam logic [15:0] OSD_STATUS_RESET = 16'h0000;

    // mask configuration layout
    localparam int OSD_MASK_HS_UC_BIT = 5;
    localparam int OSD_MASK_LS_UC_BIT = 4;
    localparam int OSD_MASK_TEMP_BIT = 3;
    localparam int OSD_MASK_UC_BIT = 1;
    localparam logic [15:0] OSD_CONFIG_WRITABLE = 16'h003A;
    localparam logic [15:0] OSD_CONFIG_RESET = 16'h0000;

    // positions of the output-one under-current flags in the first status word
    localparam int OSD_ST1_HS_UC_BIT = 15;
    localparam int OSD_ST1_LS_UC_BIT = 14;

    // open-load filter: least time, rounded up to whole clock cycles
    localparam int OSD_CLK_PERIOD_PS = 8000;
    localparam int OSD_OPEN_LOAD_FILTER_TIME_US = 1000;
    // microseconds to picoseconds before dividing by the clock period
    localparam int OSD_OPEN_LOAD_FILTER_CYCLES =
        (OSD_OPEN_LOAD_FILTER_TIME_US * 1000 * 1000 + OSD_CLK_PERIOD_PS - 1) / OSD_CLK_PERIOD_PS;

    // per-output driver state
    typedef enum logic [2:0] {
        OSD_DRV_OFF = 3'b001,
        OSD_DRV_ON = 3'b010,
        OSD_DRV_TRIP = 3'b100
    } osd_drv_state_t;

endpackage

// ---- logic/osd_diag_status.sv ----
// output seven to eleven and supply diagnostic flags, masking and summaries
//
// Notes on behaviour
// RULE1: an over-current on any of outputs seven to eleven sets its flag and turns that driver off.
// RULE2: with recovery enabled a tripped output is switched on again after a programmable off time.
// RULE3: with recovery disabled a tripped output stays off until the host clears its flag.
// RULE4: an on output whose load current stays under threshold for 1 ms gets its under-current flag.
// RULE5: the host may test for open load by switching an output on only for a few milliseconds.
// RULE6: supply under-voltage or over-voltage sets bit 3 or bit 2 and switches all outputs off.
// RULE7: outputs come back by themselves after the supply recovers only if the restart-off bit is clear.
// RULE8: the host writes zero into every reserved bit of the mask configuration word.
// RULE9: mask bit 5 keeps the output-one high-side under-current flag out of the open-load summary.
// RULE10: mask bit 4 keeps the output-one low-side under-current flag out of the open-load summary.
// RULE11: mask bit 3 keeps temperature warnings out of the global error flag.
// RULE12: mask bit 1 keeps under-current events out of the global error flag.
// RULE13: reserved bits 5, 4, 1 and 0 of the diagnostic status word always read as zero.
`timescale 1ns/1ps
`default_nettype none

module osd_diag_status #(
    parameter int NUM_OUT = osd_pkg::OSD_NUM_OUT,
    parameter int OPEN_LOAD_FILTER_CYCLES = osd_pkg::OSD_OPEN_LOAD_FILTER_CYCLES,
    parameter int RETRY_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_OUT-1:0] ocDetect,
    input wire logic [NUM_OUT-1:0] ucDetect,
    input wire logic uvDetect,
    input wire logic ovDetect,
    input wire logic tempWarnDetect,
    input wire logic [NUM_OUT-1:0] outRequest,
    input wire logic ocRecoveryEn,
    input wire logic [RETRY_WIDTH-1:0] ocRetryOffCycles,
    input wire logic supplyRestartOff,
    input wire logic [15:0] statusOneUc,
    input wire logic regSel,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    output logic [NUM_OUT-1:0] driverOn,
    output logic openLoadSummary,
    output logic globalErrorFlag
);

    localparam int PIN_W = 2 * NUM_OUT + 3;
    localparam int CNT_W = $clog2(OPEN_LOAD_FILTER_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(OPEN_LOAD_FILTER_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [RETRY_WIDTH-1:0] RETRY_ONE = RETRY_WIDTH'(1);

    // ---------------- pin synchronisers ----------------
    logic [PIN_W-1:0] syncFirst;
    logic [PIN_W-1:0] syncSecond;
    logic [PIN_W-1:0] next_syncFirst;
    logic [PIN_W-1:0] next_syncSecond;

    always_comb begin
        next_syncFirst = {ocDetect, ucDetect, uvDetect, ovDetect, tempWarnDetect};
        next_syncSecond = syncFirst;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            syncFirst <= '0;
            syncSecond <= '0;
        end else begin
            syncFirst <= next_syncFirst;
            syncSecond <= next_syncSecond;
        end
    end

    logic [NUM_OUT-1:0] ocSeen;
    logic [NUM_OUT-1:0] ucSeen;
    logic uvSeen;
    logic ovSeen;
    logic tempSeen;

    assign {ocSeen, ucSeen, uvSeen, ovSeen, tempSeen} = syncSecond;

    wire logic statusWrite = regWrite && (regSel == osd_pkg::OSD_SEL_STATUS);
    wire logic configWrite = regWrite && (regSel == osd_pkg::OSD_SEL_CONFIG);

    // ---------------- supply monitoring ----------------
    logic uvFlag;
    logic ovFlag;
    logic supplyHold;
    logic next_uvFlag;
    logic next_ovFlag;
    logic next_supplyHold;
    logic supplyBlock;

    always_comb begin
        // RULE6: sticky supply flags
        // set wins over a host clear in the same cycle
        next_uvFlag = (uvFlag && !(statusWrite && regWdata[osd_pkg::OSD_UV_BIT])) || uvSeen;
        next_ovFlag = (ovFlag && !(statusWrite && regWdata[osd_pkg::OSD_OV_BIT])) || ovSeen;
        // RULE7: restart-off latch
        // with restart off, outputs wait until the host has cleared both flags
        next_supplyHold = ((uvSeen || ovSeen) && supplyRestartOff) ||
                          (supplyHold && (next_uvFlag || next_ovFlag));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            uvFlag <= 1'b0;
            ovFlag <= 1'b0;
            supplyHold <= 1'b0;
        end else begin
            uvFlag <= next_uvFlag;
            ovFlag <= next_ovFlag;
            supplyHold <= next_supplyHold;
        end
    end

    // RULE6: all outputs off
    assign supplyBlock = uvSeen || ovSeen || supplyHold;

    // ---------------- per-output protection ----------------
    logic [NUM_OUT-1:0] ocFlag;
    logic [NUM_OUT-1:0] ucFlag;

    for (genvar k = 0; k < NUM_OUT; k++) begin : gOut
        osd_pkg::osd_drv_state_t state;
        osd_pkg::osd_drv_state_t next_state;
        logic [RETRY_WIDTH-1:0] retryCnt;
        logic [RETRY_WIDTH-1:0] next_retryCnt;
        logic [CNT_W-1:0] ucCnt;
        logic [CNT_W-1:0] next_ucCnt;
        logic next_ocFlag;
        logic next_ucFlag;
        logic next_driverOn;
        logic clearOc;
        logic clearUc;
        logic ucHit;

        assign clearOc = statusWrite && regWdata[osd_pkg::OSD_OC_TOP_BIT - 2 * k];
        assign clearUc = statusWrite && regWdata[osd_pkg::OSD_UC_TOP_BIT - 2 * k];

        always_comb begin
            next_state = state;
            next_retryCnt = retryCnt;
            next_ocFlag = ocFlag[k] && !clearOc;
            next_ucCnt = '0;
            ucHit = 1'b0;
            unique case (state)
                osd_pkg::OSD_DRV_OFF: begin
                    if (outRequest[k] && !supplyBlock) begin
                        next_state = osd_pkg::OSD_DRV_ON;
                    end
                end
                osd_pkg::OSD_DRV_ON: begin
                    if (ocSeen[k]) begin
                        // RULE1: trip and latch
                        next_ocFlag = 1'b1;
                        next_state = osd_pkg::OSD_DRV_TRIP;
                        next_retryCnt = '0;
                    end else if (!outRequest[k] || supplyBlock) begin
                        next_state = osd_pkg::OSD_DRV_OFF;
                    end
                end
                osd_pkg::OSD_DRV_TRIP: begin
                    if (ocRecoveryEn) begin
                        // RULE2: timed retry
                        // off time sets the duty cycle of the retried load current
                        if (retryCnt >= ocRetryOffCycles) begin
                            next_state = osd_pkg::OSD_DRV_OFF;
                        end else begin
                            next_retryCnt = retryCnt + RETRY_ONE;
                        end
                    end else if (!ocFlag[k]) begin
                        // RULE3: host clear releases
                        next_state = osd_pkg::OSD_DRV_OFF;
                    end
                end
            endcase
            // RULE4: open-load filter
            // counts only while the stage is really on; any gap restarts it
            if (state == osd_pkg::OSD_DRV_ON && ucSeen[k]) begin
                if (ucCnt >= CNT_LAST) begin
                    next_ucCnt = ucCnt;
                    ucHit = 1'b1;
                end else begin
                    next_ucCnt = ucCnt + CNT_ONE;
                end
            end
            next_ucFlag = (ucFlag[k] && !clearUc) || ucHit;
            next_driverOn = (next_state == osd_pkg::OSD_DRV_ON);
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                state <= osd_pkg::OSD_DRV_OFF;
                retryCnt <= '0;
                ucCnt <= '0;
                ocFlag[k] <= 1'b0;
                ucFlag[k] <= 1'b0;
                driverOn[k] <= 1'b0;
            end else begin
                state <= next_state;
                retryCnt <= next_retryCnt;
                ucCnt <= next_ucCnt;
                ocFlag[k] <= next_ocFlag;
                ucFlag[k] <= next_ucFlag;
                driverOn[k] <= next_driverOn;
            end
        end
    end

    // ---------------- mask configuration ----------------
    logic [15:0] maskConfig;
    logic [15:0] next_maskConfig;

    always_comb begin
        // RULE8: reserved bits dropped
        // reserved bits are not stored, so a careless write cannot enable anything
        next_maskConfig = maskConfig;
        if (configWrite) begin
            next_maskConfig = regWdata & osd_pkg::OSD_CONFIG_WRITABLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            maskConfig <= osd_pkg::OSD_CONFIG_RESET;
        end else begin
            maskConfig <= next_maskConfig;
        end
    end

    // ---------------- status word and summaries ----------------
    logic [15:0] statusWord;
    logic [15:0] otherUcMasked;
    logic openLoadAny;
    logic next_openLoadSummary;
    logic next_globalErrorFlag;
    logic [15:0] next_regRdata;

    always_comb begin
        // RULE13: reserved bits zero
        statusWord = osd_pkg::OSD_STATUS_RESET;
        for (int i = 0; i < NUM_OUT; i++) begin
            statusWord[osd_pkg::OSD_OC_TOP_BIT - 2 * i] = ocFlag[i];
            statusWord[osd_pkg::OSD_UC_TOP_BIT - 2 * i] = ucFlag[i];
        end
        statusWord[osd_pkg::OSD_UV_BIT] = uvFlag;
        statusWord[osd_pkg::OSD_OV_BIT] = ovFlag;

        otherUcMasked = statusOneUc;
        // RULE9: high-side mask
        if (maskConfig[osd_pkg::OSD_MASK_HS_UC_BIT]) begin
            otherUcMasked[osd_pkg::OSD_ST1_HS_UC_BIT] = 1'b0;
        end
        // RULE10: low-side mask
        if (maskConfig[osd_pkg::OSD_MASK_LS_UC_BIT]) begin
            otherUcMasked[osd_pkg::OSD_ST1_LS_UC_BIT] = 1'b0;
        end
        openLoadAny = (|ucFlag) || (|otherUcMasked);
        next_openLoadSummary = openLoadAny;

        // RULE11: temperature mask
        // RULE12: open-load mask
        next_globalErrorFlag = (|ocFlag) || uvFlag || ovFlag ||
                               (tempSeen && !maskConfig[osd_pkg::OSD_MASK_TEMP_BIT]) ||
                               (openLoadAny && !maskConfig[osd_pkg::OSD_MASK_UC_BIT]);

        // read data holds until the next read
        next_regRdata = regRdata;
        if (regRead) begin
            next_regRdata = (regSel == osd_pkg::OSD_SEL_STATUS) ? statusWord : maskConfig;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            openLoadSummary <= 1'b0;
            globalErrorFlag <= 1'b0;
            regRdata <= osd_pkg::OSD_STATUS_RESET;
        end else begin
            openLoadSummary <= next_openLoadSummary;
            globalErrorFlag <= next_globalErrorFlag;
            regRdata <= next_regRdata;
        end
    end

endmodule

`default_nettype wire

// ---- test/osd_diag_status_assertions.sv ----
// port assertions for the diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module osd_diag_status_checker #(
    parameter int NUM_OUT = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_OUT-1:0] ocDetect,
    input wire logic uvDetect,
    input wire logic ovDetect,
    input wire logic [NUM_OUT-1:0] outRequest,
    input wire logic ocRecoveryEn,
    input wire logic regSel,
    input wire logic regRead,
    input wire logic [15:0] regRdata,
    input wire logic [NUM_OUT-1:0] driverOn,
    input wire logic globalErrorFlag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // two sync stages plus one edge
    property p_oc_off;
        (ocDetect[0] && !ocRecoveryEn)[*3] |=> !driverOn[0];
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("driver on after over-current");
    property p_uv_off;
        uvDetect[*3] |=> driverOn == '0;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("driver on in under-voltage");
    property p_ov_off;
        ovDetect[*3] |=> driverOn == '0;
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("driver on in over-voltage");
    property p_req;
        (driverOn & ~$past(outRequest)) == '0;
    endproperty
    a_req: assert property (p_req) else $error("driver on without request");
    property p_glob;
        (uvDetect || ovDetect)[*3] |-> ##[1:3] globalErrorFlag;
    endproperty
    a_glob: assert property (p_glob) else $error("supply fault not in error flag");
    property p_rsv_st;
        (regRead && !regSel) |=> (regRdata & 16'h0033) == 16'h0000;
    endproperty
    a_rsv_st: assert property (p_rsv_st) else $error("status reserved bit set");
    property p_rsv_cfg;
        (regRead && regSel) |=> (regRdata & 16'hFFC5) == 16'h0000;
    endproperty
    a_rsv_cfg: assert property (p_rsv_cfg) else $error("config reserved bit set");
    property p_hold;
        !regRead |=> $stable(regRdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind osd_diag_status osd_diag_status_checker #(.NUM_OUT(NUM_OUT)) osd_diag_status_checker_inst (
    .clk(clk), .rst(rst), .ocDetect(ocDetect), .uvDetect(uvDetect), .ovDetect(ovDetect),
    .outRequest(outRequest), .ocRecoveryEn(ocRecoveryEn), .regSel(regSel), .regRead(regRead),
    .regRdata(regRdata), .driverOn(driverOn), .globalErrorFlag(globalErrorFlag));
`default_nettype wire

// ---- test/osd_host_model.sv ----
// host model driving the register strobes
`timescale 1ns/1ps
`default_nettype none
module osd_host_model (
    input wire logic clk,
    input wire logic [15:0] regRdata,
    output logic regSel,
    output logic regWrite,
    output logic regRead,
    output logic [15:0] regWdata
);
    initial begin
        {regSel, regWrite, regRead} = '0;
        regWdata = '0;
    end
    // strobes move on the falling edge so each is held over one rising edge
    task automatic wr(input logic s, input logic [15:0] d);
        @(negedge clk);
        regSel = s;
        regWrite = 1'b1;
        regWdata = s ? (d & 16'h003A) : d;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic s, output logic [15:0] d);
        @(negedge clk);
        regSel = s;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        d = regRdata;
    endtask
endmodule
`default_nettype wire

// ---- test/osd_diag_status_bench.sv ----
// self-checking bench for the diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module osd_diag_status_bench;
    logic clk, rst, uvDetect, ovDetect, tempWarnDetect, ocRecoveryEn, supplyRestartOff;
    logic [4:0] ocDetect, ucDetect, outRequest, driverOn;
    logic [15:0] ocRetryOffCycles, statusOneUc, regWdata, regRdata, rdv;
    logic regSel, regWrite, regRead, openLoadSummary, globalErrorFlag;
    int errors = 0;
    int total_checks = 0;
    // short filter keeps the open-load test brief
    osd_diag_status #(.OPEN_LOAD_FILTER_CYCLES(8)) osd_diag_status_inst (.clk(clk), .rst(rst),
        .ocDetect(ocDetect), .ucDetect(ucDetect), .uvDetect(uvDetect), .ovDetect(ovDetect),
        .tempWarnDetect(tempWarnDetect), .outRequest(outRequest), .ocRecoveryEn(ocRecoveryEn),
        .ocRetryOffCycles(ocRetryOffCycles), .supplyRestartOff(supplyRestartOff),
        .statusOneUc(statusOneUc), .regSel(regSel), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .driverOn(driverOn),
        .openLoadSummary(openLoadSummary), .globalErrorFlag(globalErrorFlag));
    osd_host_model osd_host_model_inst (.clk(clk), .regRdata(regRdata), .regSel(regSel),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic s, input logic [15:0] d);
        osd_host_model_inst.wr(s, d);
    endtask
    task automatic rdc(input logic s, input logic [15:0] exp);
        osd_host_model_inst.rd(s, rdv);
        chk(rdv, exp);
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic t_reset;
        chk(16'(driverOn), 16'h0000);
        rdc(1'h0, 16'h0000);
        wr(1'h1, 16'hFFFF);
        rdc(1'h1, 16'h003A);
        wr(1'h1, 16'h0000);
    endtask
    task automatic t_oc;
        for (int k = 0; k < 5; k++) begin
            outRequest = 5'(1 << k);
            cyc(3);
            chk(16'(driverOn), 16'(outRequest));
            ocDetect = outRequest;
            cyc(4);
            chk(16'(driverOn), 16'h0000);
            ocDetect = 5'h00;
            cyc(6);
            chk(16'(driverOn), 16'h0000);
            rdc(1'h0, 16'h8000 >> (2 * k));
            wr(1'h0, 16'h8000 >> (2 * k));
            cyc(3);
            chk(16'(driverOn), 16'(outRequest));
        end
    endtask
    task automatic t_retry;
        ocRecoveryEn = 1'b1;
        ocRetryOffCycles = 16'h0004;
        outRequest = 5'h01;
        cyc(3);
        ocDetect = 5'h01;
        cyc(4);
        chk(16'(driverOn), 16'h0000);
        ocDetect = 5'h00;
        cyc(12);
        chk(16'(driverOn), 16'h0001);
        rdc(1'h0, 16'h8000);
        wr(1'h0, 16'h8000);
        ocRecoveryEn = 1'b0;
    endtask
    task automatic t_supply;
        supplyRestartOff = 1'b1;
        outRequest = 5'h1F;
        cyc(3);
        uvDetect = 1'b1;
        cyc(4);
        chk(16'(driverOn), 16'h0000);
        uvDetect = 1'b0;
        cyc(5);
        chk(16'(driverOn), 16'h0000);
        rdc(1'h0, 16'h0008);
        wr(1'h0, 16'h0008);
        cyc(3);
        chk(16'(driverOn), 16'h001F);
        supplyRestartOff = 1'b0;
        ovDetect = 1'b1;
        cyc(4);
        chk(16'(driverOn), 16'h0000);
        rdc(1'h0, 16'h0004);
        ovDetect = 1'b0;
        cyc(5);
        chk(16'(driverOn), 16'h001F);
        wr(1'h0, 16'h0004);
    endtask
    task automatic t_mask;
        outRequest = 5'h02;
        ucDetect = 5'h06;
        cyc(16);
        rdc(1'h0, 16'h1000);
        chk({14'h0, openLoadSummary, globalErrorFlag}, 16'h0003);
        wr(1'h1, 16'h0002);
        cyc(3);
        chk({14'h0, openLoadSummary, globalErrorFlag}, 16'h0002);
        outRequest = 5'h00;
        ucDetect = 5'h00;
        wr(1'h0, 16'h1000);
        wr(1'h1, 16'h0000);
        statusOneUc = 16'h8000;
        cyc(3);
        chk({14'h0, openLoadSummary, globalErrorFlag}, 16'h0003);
        wr(1'h1, 16'h0020);
        statusOneUc = 16'hC000;
        cyc(3);
        chk({14'h0, openLoadSummary, globalErrorFlag}, 16'h0003);
        wr(1'h1, 16'h0030);
        cyc(3);
        chk({14'h0, openLoadSummary, globalErrorFlag}, 16'h0000);
        tempWarnDetect = 1'b1;
        cyc(4);
        chk({14'h0, openLoadSummary, globalErrorFlag}, 16'h0001);
        wr(1'h1, 16'h0038);
        cyc(3);
        chk({14'h0, openLoadSummary, globalErrorFlag}, 16'h0000);
    endtask
    // mid-run reset must drop a latched flag and the mask word
    task automatic t_rerun;
        outRequest = 5'h01;
        cyc(3);
        ocDetect = 5'h01;
        cyc(4);
        ocDetect = 5'h00;
        outRequest = 5'h00;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        chk(16'(driverOn), 16'h0000);
        rdc(1'h0, 16'h0000);
        rdc(1'h1, 16'h0000);
    endtask
    initial begin
        rst = 1'b1;
        {ocDetect, ucDetect, outRequest} = '0;
        {uvDetect, ovDetect, tempWarnDetect, ocRecoveryEn, supplyRestartOff} = '0;
        ocRetryOffCycles = '0;
        statusOneUc = '0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_oc;
        t_retry;
        t_supply;
        t_mask;
        t_rerun;
        end_of_test;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #50000;
        errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
